// File: shared/clock_startup_pkg.sv
// Purpose: Constants and types for the clock start-up selector.
// Assumes: Fuse settings are stable while the block runs.
// Notes: Tick counts are in cycles of the oscillator that paces each phase.
`default_nettype none
package clock_startup_pkg;
  localparam logic [3:0] SRC_RC_OSC = 4'h2;
  localparam logic [2:0] SRC_LF_XTAL_HI = 3'h2;
  localparam logic [1:0] TMO_NONE = 2'h0;
  localparam logic [1:0] TMO_FAST_RISE = 2'h1;
  localparam logic [1:0] TMO_SLOW_RISE = 2'h2;
  localparam logic [1:0] TMO_RESERVED = 2'h3;
  // Shipped configuration
  localparam logic [3:0] DEFAULT_SOURCE = SRC_RC_OSC;
  localparam logic [1:0] DEFAULT_TMO = TMO_SLOW_RISE;
  localparam logic DEFAULT_DIV8 = 1'b1;
  localparam int CNT_W = 17;
  localparam logic [CNT_W-1:0] RESET_OSC_TICKS = 17'h0000E;
  localparam logic [CNT_W-1:0] WAKE_LF_SHORT = 17'h00400;
  localparam logic [CNT_W-1:0] WAKE_LF_LONG = 17'h08000;
  localparam logic [CNT_W-1:0] WAKE_RC = 17'h00006;
  localparam int FAST_RISE_NS = 4100000;
  localparam int SLOW_RISE_NS = 65000000;
  localparam int DIV8_W = 3;
  localparam logic [DIV8_W-1:0] DIV8_PHASE = 3'h0;
  localparam logic [7:0] TRIM_RESET = 8'h00;

  typedef struct packed {
    logic [3:0] source;
    logic [1:0] startup_time_field;
    logic div8;
  } clk_cfg_t;

  // Gray codes along reset -> timeout -> run -> sleep -> wake; wake back to run flips two bits
  typedef enum logic [2:0] {
    ST_RST_OSC = 3'h0,
    ST_RST_TMO = 3'h1,
    ST_RUN = 3'h3,
    ST_SLEEP = 3'h2,
    ST_WAKE = 3'h6,
    ST_HALT = 3'h7
  } su_state_t;
endpackage
`default_nettype wire

// File: src/clock_startup_select.sv
// Purpose: Start-up delay sequencing, clock gating and RC trim loading.
// Assumes: osc_tick pulses once per selected oscillator cycle, wdt_tick once per
//   watchdog oscillator cycle; both are synchronous one-cycle pulses on clk.
// Notes: Reserved start-up code parks the block in a halt state with the clock gated.
// Operation
// - Low-frequency crystal with select bit 0 waits 1K cycles on wake, reset adds 14 plus timeout.
// - Low-frequency crystal with select bit 1 waits 32K cycles on wake, same reset delays.
// - Low-frequency start-up code 00 adds 14, 01 adds 14 plus 4.1 ms, 10 plus 65 ms, 11 reserved.
// - Clock source code 0010 selects the internal RC oscillator as system clock.
// - RC oscillator waits 6 cycles on wake, and 14 plus 0, 4.1 or 65 ms after reset.
// - Every reset copies the factory calibration byte into the RC trim register.
// - Software may rewrite the RC trim register after reset to retune the oscillator.
// - The reset time-out is timed by the watchdog oscillator, not the RC oscillator.
// - Shipped configuration has divide-by-eight programmed, which divides the clock by 8.
// - Shipped configuration selects the RC oscillator with start-up code 10.
`default_nettype none
module clock_startup_select
  import clock_startup_pkg::*;
#(
  parameter int WDT_PERIOD_NS = 7813,
  parameter int FAST_RISE_TICKS = (FAST_RISE_NS + WDT_PERIOD_NS - 1) / WDT_PERIOD_NS,
  parameter int SLOW_RISE_TICKS = (SLOW_RISE_NS + WDT_PERIOD_NS - 1) / WDT_PERIOD_NS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Fuse settings
  input wire clk_cfg_t fuse_cfg,
  input wire logic use_factory_default,
  input wire logic [7:0] factory_cal,
  // Oscillator pacing
  input wire logic osc_tick,
  input wire logic wdt_tick,
  // Power management
  input wire logic sleep_req,
  input wire logic wake_req,
  // Software trim access
  input wire logic trim_wr,
  input wire logic [7:0] trim_wdata,
  // Results
  output logic sys_clk_gate,
  output logic [7:0] rc_trim_register,
  output logic rc_osc_selected,
  output logic div8_active,
  output logic config_error,
  output logic startup_busy
);

  su_state_t state_reg, state_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic [DIV8_W-1:0] div_reg, div_next;
  logic [7:0] trim_reg, trim_next;
  logic gate_reg, rc_reg, div8_reg, err_reg, busy_reg;

  wire clk_cfg_t cfg = use_factory_default ?
    clk_cfg_t'{source: DEFAULT_SOURCE, startup_time_field: DEFAULT_TMO, div8: DEFAULT_DIV8} :
    fuse_cfg;
  wire logic is_rc = cfg.source == SRC_RC_OSC;
  wire logic is_lf = cfg.source[3:1] == SRC_LF_XTAL_HI;
  wire logic startup_select_bit = cfg.source[0];
  wire logic reserved = cfg.startup_time_field == TMO_RESERVED;

  function automatic logic [CNT_W-1:0] wake_ticks(input logic lf, input logic sel);
    if (lf) begin
      return sel ? WAKE_LF_LONG : WAKE_LF_SHORT;
    end
    return WAKE_RC;
  endfunction

  function automatic logic [CNT_W-1:0] tmo_ticks(input logic [1:0] code);
    return (code == TMO_FAST_RISE) ? CNT_W'(FAST_RISE_TICKS) : CNT_W'(SLOW_RISE_TICKS);
  endfunction

  wire logic [CNT_W-1:0] wake_target = wake_ticks(is_lf, startup_select_bit);
  wire logic [CNT_W-1:0] tmo_target = tmo_ticks(cfg.startup_time_field);
  wire logic osc_last = osc_tick && (cnt_reg == RESET_OSC_TICKS - 1'b1);
  wire logic wake_last = osc_tick && (cnt_reg == wake_target - 1'b1);
  wire logic tmo_last = wdt_tick && (cnt_reg == tmo_target - 1'b1);
  wire logic cnt_inc_osc = osc_tick && !osc_last;

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    unique case (state_reg)
      ST_RST_OSC: begin
        if (reserved) begin
          state_next = ST_HALT;
        end else if (osc_last) begin
          cnt_next = '0;
          state_next = (cfg.startup_time_field == TMO_NONE) ? ST_RUN : ST_RST_TMO;
        end else if (cnt_inc_osc) begin
          cnt_next = cnt_reg + 1'b1;
        end
      end
      ST_RST_TMO: begin
        if (tmo_last) begin
          cnt_next = '0;
          state_next = ST_RUN;
        end else if (wdt_tick) begin
          cnt_next = cnt_reg + 1'b1;
        end
      end
      ST_RUN: begin
        if (sleep_req) begin
          state_next = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (wake_req) begin
          cnt_next = '0;
          state_next = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (wake_last) begin
          cnt_next = '0;
          state_next = ST_RUN;
        end else if (osc_tick) begin
          cnt_next = cnt_reg + 1'b1;
        end
      end
      ST_HALT: begin
        state_next = ST_HALT;
      end
      default: begin
        state_next = ST_HALT;
      end
    endcase
  end

  assign div_next = (state_next == ST_RUN) ? div_reg + 1'b1 : DIV8_PHASE;
  wire logic gate_next = (state_next == ST_RUN) && (!cfg.div8 || div_next == DIV8_PHASE);

  always_comb begin
    trim_next = trim_reg;
    if (state_reg == ST_RST_OSC || state_reg == ST_RST_TMO || state_reg == ST_HALT) begin
      trim_next = factory_cal;
    end else if (trim_wr) begin
      trim_next = trim_wdata;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= ST_RST_OSC;
      cnt_reg <= '0;
      div_reg <= DIV8_PHASE;
      trim_reg <= TRIM_RESET;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      div_reg <= div_next;
      trim_reg <= trim_next;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gate_reg <= 1'b0;
      rc_reg <= 1'b0;
      div8_reg <= 1'b0;
      err_reg <= 1'b0;
      busy_reg <= 1'b1;
    end else begin
      gate_reg <= gate_next;
      rc_reg <= is_rc;
      div8_reg <= cfg.div8;
      err_reg <= (state_next == ST_HALT);
      busy_reg <= (state_next != ST_RUN) && (state_next != ST_SLEEP);
    end
  end

  assign sys_clk_gate = gate_reg;
  assign rc_trim_register = trim_reg;
  assign rc_osc_selected = rc_reg;
  assign div8_active = div8_reg;
  assign config_error = err_reg;
  assign startup_busy = busy_reg;

  property p_reserved_halts;
    @(posedge clk) disable iff (!rstn)
      (state_reg == ST_RST_OSC && reserved) |=> state_reg == ST_HALT ##1 config_error;
  endproperty
  a_reserved_halts: assert property (p_reserved_halts)
    else $error("reserved start-up code did not halt");

  property p_gate_only_run;
    @(posedge clk) disable iff (!rstn)
      sys_clk_gate |-> state_reg == ST_RUN;
  endproperty
  a_gate_only_run: assert property (p_gate_only_run)
    else $error("clock enabled outside run");

  property p_trim_load;
    @(posedge clk) disable iff (!rstn)
      (state_reg == ST_RST_OSC) |=> rc_trim_register == $past(factory_cal);
  endproperty
  a_trim_load: assert property (p_trim_load)
    else $error("calibration not loaded during reset");

  property p_trim_write;
    @(posedge clk) disable iff (!rstn)
      (state_reg == ST_RUN && trim_wr) |=> rc_trim_register == $past(trim_wdata);
  endproperty
  a_trim_write: assert property (p_trim_write)
    else $error("software trim write lost");

  property p_wake_done;
    @(posedge clk) disable iff (!rstn)
      (state_reg == ST_WAKE && $rose(state_next == ST_RUN)) |->
        osc_tick && cnt_reg == wake_target - 1'b1;
  endproperty
  a_wake_done: assert property (p_wake_done)
    else $error("wake delay ended at wrong count");

  property p_rc_wake_six;
    @(posedge clk) disable iff (!rstn)
      (state_reg == ST_WAKE && is_rc && osc_tick && cnt_reg == WAKE_RC - 1'b1)
        |=> state_reg == ST_RUN;
  endproperty
  a_rc_wake_six: assert property (p_rc_wake_six)
    else $error("RC wake did not end after 6 cycles");

  property p_no_timeout;
    @(posedge clk) disable iff (!rstn)
      (state_reg == ST_RST_OSC && osc_last && cfg.startup_time_field == TMO_NONE && !reserved)
        |=> state_reg == ST_RUN ##1 (sys_clk_gate || cfg.div8);
  endproperty
  a_no_timeout: assert property (p_no_timeout)
    else $error("code 00 did not run after 14 cycles");

  property p_tmo_wdt;
    @(posedge clk) disable iff (!rstn)
      (state_reg == ST_RST_TMO && state_next == ST_RUN) |-> wdt_tick && tmo_last;
  endproperty
  a_tmo_wdt: assert property (p_tmo_wdt)
    else $error("reset timeout not paced by watchdog");

  property p_div8_spacing;
    @(posedge clk) disable iff (!rstn)
      (sys_clk_gate && div8_active && $stable(cfg.div8) && cfg.div8) |=> !sys_clk_gate [*7];
  endproperty
  a_div8_spacing: assert property (p_div8_spacing)
    else $error("divided clock enable too frequent");

  property p_default_cfg;
    @(posedge clk) disable iff (!rstn)
      use_factory_default |-> (is_rc && cfg.startup_time_field == TMO_SLOW_RISE && cfg.div8)
        ##1 (rc_osc_selected && div8_active && !config_error);
  endproperty
  a_default_cfg: assert property (p_default_cfg)
    else $error("factory default configuration wrong");

endmodule
`default_nettype wire

// File: tb/tb_top.sv
// Purpose: Self-checking bench for the clock start-up selector.
// Assumes: Oscillator ticks are one-cycle pulses driven every other clock.
// Notes: Timeout counts are shortened through the tick parameters.
`default_nettype none
module tb_top
  import clock_startup_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int FAST_T = 3;
  localparam int SLOW_T = 5;
  logic clk = 1'h0;
  logic rstn = 1'h0;
  clk_cfg_t fuse_cfg = '0;
  logic use_def = 1'h0;
  logic [7:0] cal = 8'h00;
  logic osc_tick = 1'h0;
  logic wdt_tick = 1'h0;
  logic sleep_req = 1'h0;
  logic wake_req = 1'h0;
  logic trim_wr = 1'h0;
  logic [7:0] trim_wdata = 8'h00;
  logic gate, rc_sel, div8, cfg_err, busy;
  logic [7:0] trim;
  int fail_count = 0;
  int tests_run = 0;
  int highs;

  always #2.5 clk = ~clk;

  clock_startup_select #(.FAST_RISE_TICKS(FAST_T), .SLOW_RISE_TICKS(SLOW_T))
    clock_startup_select_i (
    .clk(clk), .rstn(rstn), .fuse_cfg(fuse_cfg), .use_factory_default(use_def),
    .factory_cal(cal), .osc_tick(osc_tick), .wdt_tick(wdt_tick),
    .sleep_req(sleep_req), .wake_req(wake_req), .trim_wr(trim_wr),
    .trim_wdata(trim_wdata), .sys_clk_gate(gate), .rc_trim_register(trim),
    .rc_osc_selected(rc_sel), .div8_active(div8), .config_error(cfg_err),
    .startup_busy(busy));

  task automatic give_verdict;
    $display("Checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk_bit(input string what, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Spaced pulses so no two ticks merge into one level
  task automatic ticks(input logic w, input int n);
    repeat (n) begin
      @(negedge clk);
      osc_tick = !w;
      wdt_tick = w;
      @(negedge clk);
      osc_tick = 1'h0;
      wdt_tick = 1'h0;
    end
  endtask

  task automatic do_reset(input logic [3:0] src, input logic [1:0] tcode, input logic d8,
                          input logic [7:0] c);
    @(negedge clk);
    rstn = 1'h0;
    fuse_cfg = '{src, tcode, d8};
    cal = c;
    repeat (20) @(negedge clk);
    chk_bit("gate_rst", 1'h0, gate);
    chk_byte("trim_rst", 8'h00, trim);
    chk_bit("busy_rst", 1'h1, busy);
    rstn = 1'h1;
    trim_wr = 1'h1;
    trim_wdata = ~c;
    @(negedge clk);
    trim_wr = 1'h0;
    chk_byte("trim_load", c, trim);
  endtask

  task automatic boot(input logic [3:0] src, input logic [1:0] tcode, input logic [7:0] c,
                      input int nw);
    do_reset(src, tcode, 1'h0, c);
    ticks(1'h0, 13);
    chk_bit("busy_13", 1'h1, busy);
    ticks(1'h0, 1);
    if (nw > 0) begin
      chk_bit("busy_tmo", 1'h1, busy);
      ticks(1'h0, 20);
      chk_bit("busy_osc_only", 1'h1, busy);
      ticks(1'h1, nw - 1);
      chk_bit("busy_wdt_last", 1'h1, busy);
      ticks(1'h1, 1);
    end
    chk_bit("busy_done", 1'h0, busy);
    @(negedge clk);
    chk_bit("gate_run", 1'h1, gate);
  endtask

  task automatic nap_wake(input int n);
    @(negedge clk);
    sleep_req = 1'h1;
    @(negedge clk);
    sleep_req = 1'h0;
    @(negedge clk);
    chk_bit("gate_sleep", 1'h0, gate);
    wake_req = 1'h1;
    @(negedge clk);
    wake_req = 1'h0;
    ticks(1'h0, n - 1);
    chk_bit("busy_wake", 1'h1, busy);
    ticks(1'h0, 1);
    chk_bit("busy_woke", 1'h0, busy);
    @(negedge clk);
    chk_bit("gate_woke", 1'h1, gate);
  endtask

  initial begin
    boot(SRC_RC_OSC, TMO_NONE, 8'hA5, 0);
    chk_bit("rc_sel", 1'h1, rc_sel);
    chk_bit("div8_off", 1'h0, div8);
    trim_wr = 1'h1;
    trim_wdata = 8'h3C;
    @(negedge clk);
    trim_wr = 1'h0;
    chk_byte("trim_sw", 8'h3C, trim);
    nap_wake(6);
    chk_byte("trim_kept", 8'h3C, trim);
    for (int s = 0; s < 2; s++) begin
      boot({SRC_LF_XTAL_HI, s[0]}, TMO_NONE, 8'h5A, 0);
      chk_bit("lf_not_rc", 1'h0, rc_sel);
      nap_wake((s == 0) ? 1024 : 32768);
    end
    boot(SRC_RC_OSC, TMO_FAST_RISE, 8'h11, FAST_T);
    boot({SRC_LF_XTAL_HI, 1'h1}, TMO_SLOW_RISE, 8'h22, SLOW_T);
    // Shipped defaults must override a reserved fuse pattern
    // Configuration only changes under reset, as fuses would
    @(negedge clk);
    rstn = 1'h0;
    use_def = 1'h1;
    do_reset({SRC_LF_XTAL_HI, 1'h0}, TMO_RESERVED, 1'h0, 8'h77);
    chk_bit("def_rc", 1'h1, rc_sel);
    chk_bit("def_div8", 1'h1, div8);
    ticks(1'h0, 14);
    ticks(1'h1, SLOW_T - 1);
    chk_bit("def_busy", 1'h1, busy);
    ticks(1'h1, 1);
    chk_bit("def_done", 1'h0, busy);
    repeat (10) @(negedge clk);
    highs = 0;
    repeat (16) begin
      @(negedge clk);
      highs += (gate === 1'h1);
    end
    chk_byte("div8_highs", 8'h02, highs[7:0]);
    @(negedge clk);
    rstn = 1'h0;
    use_def = 1'h0;
    do_reset({SRC_LF_XTAL_HI, 1'h1}, TMO_RESERVED, 1'h0, 8'h33);
    ticks(1'h0, 14);
    ticks(1'h1, 8);
    chk_bit("rsv_err", 1'h1, cfg_err);
    chk_bit("rsv_gate", 1'h0, gate);
    chk_bit("rsv_busy", 1'h1, busy);
    give_verdict();
  end
endmodule
`default_nettype wire
